// [hdl/sie_pkg.sv]
// Constants, types and configuration carrier for the safety input evaluator.
package sie_pkg;

   localparam int unsigned CLK_FREQ_HZ = 32'h02FA_F080;
   localparam int unsigned MS_PER_S = 32'h0000_03E8;
   localparam int unsigned CYCLES_PER_MS = CLK_FREQ_HZ / MS_PER_S;

   localparam int unsigned NUM_CH = 4;
   localparam int unsigned NUM_FLT = 5;
   localparam int unsigned RST_CH = 4;

   localparam logic [7:0] FILTER_MIN_MS = 8'h03;
   localparam logic [7:0] FILTER_MAX_MS = 8'hFA;
   localparam logic [9:0] TH_WINDOW_MS = 10'h1F4;
   localparam logic [9:0] LB_REACT_MAX_MS = 10'h014;
   localparam logic [9:0] TP_MARGIN_MS = 10'h005;
   localparam logic [9:0] TP_LOW_MS = LB_REACT_MAX_MS + TP_MARGIN_MS;
   localparam logic [9:0] TP_RECOVER_MS = LB_REACT_MAX_MS + TP_MARGIN_MS;
   localparam logic [9:0] TP_PERIOD_MS = 10'h3E8;

   localparam logic OUT_RST = 1'b0;
   localparam logic ERR_RST = 1'b0;
   localparam logic [3:0] MODE_OUT_RST = 4'h0;
   localparam logic [3:0] TEST_IDLE = 4'hF;

   localparam logic [1:0] IT_SINGLE_NC = 2'h0;
   localparam logic [1:0] IT_SINGLE_NO = 2'h1;
   localparam logic [1:0] IT_DOUBLE_NC = 2'h2;
   localparam logic [1:0] IT_NC_NO = 2'h3;
   localparam logic [1:0] IT_TH_DOUBLE_NO = 2'h0;
   localparam logic [1:0] IT_TH_QUAD = 2'h1;
   localparam logic [1:0] IT_NET_SINGLE = 2'h0;
   localparam logic [1:0] IT_NET_DOUBLE = 2'h1;
   localparam logic [1:0] POS_TWO = 2'h0;
   localparam logic [1:0] POS_THREE = 2'h1;
   localparam logic [1:0] POS_FOUR = 2'h2;

   typedef enum logic [2:0] {
      EV_FOOTSWITCH = 3'h0,
      EV_MODE_SEL = 3'h1,
      EV_LIGHT_BARRIER = 3'h2,
      EV_TWO_HAND = 3'h3,
      EV_NETWORK = 3'h4,
      EV_SENSOR = 3'h5
   } sie_eval_t;

   typedef enum logic [1:0] {
      RM_NONE = 2'h0,
      RM_MANUAL = 2'h1,
      RM_MONITORED = 2'h2
   } sie_rst_mode_t;

   typedef enum logic [2:0] {
      ST_START = 3'b000,
      ST_START_SEEN = 3'b001,
      ST_OFF = 3'b011,
      ST_ARMED = 3'b010,
      ST_ON = 3'b110
   } sie_state_t;

   typedef enum logic [1:0] {
      TP_IDLE = 2'b00,
      TP_LOW = 2'b01,
      TP_RECOVER = 2'b11
   } sie_tp_t;

   typedef enum logic [1:0] {
      TH_IDLE = 2'b00,
      TH_FIRST = 2'b01,
      TH_ON = 2'b11,
      TH_LOCKED = 2'b10
   } sie_th_t;

   typedef struct packed {
      sie_eval_t eval_kind;
      logic [1:0] input_type;
      sie_rst_mode_t reset_mode;
      logic [7:0] filter_ms;
      logic simult_en;
      logic [9:0] simult_ms;
      logic err_out_en;
      logic startup_en;
      logic test_en;
      logic [1:0] test_sel;
      logic [1:0] positions;
   } sie_cfg_t;

endpackage : sie_pkg

// [hdl/sie_debounce.sv]
// Debounce filter for one input line, counted in millisecond ticks.
`timescale 1ns/1ps
module sie_debounce (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic clk_en_in,
   input wire logic ms_tick_in,
   input wire logic hold_in,
   input wire logic [7:0] filter_ms_in,
   input wire logic raw_in,
   output logic clean_out
);

   logic [7:0] cnt_reg;
   logic clean_reg;

   // The clean level changes only after the raw level has differed for the full filter time.
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cnt_reg <= 8'h00;
         clean_reg <= 1'b0;
      end else if (clk_en_in) begin
         if (hold_in || (raw_in == clean_reg)) begin
            cnt_reg <= 8'h00;
         end else if (ms_tick_in) begin
            if (cnt_reg + 8'h01 >= filter_ms_in) begin
               clean_reg <= raw_in;
               cnt_reg <= 8'h00;
            end else begin
               cnt_reg <= cnt_reg + 8'h01;
            end
         end
      end
   end

   assign clean_out = clean_reg;

endmodule : sie_debounce

// [hdl/sie_eval.sv]
// Top of the safety input evaluator with reset, start-up, test pulse and error logic.
`timescale 1ns/1ps
module sie_eval #(
   parameter int unsigned CYCLES_PER_MS = sie_pkg::CYCLES_PER_MS
) (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic clk_en_in,
   input wire sie_pkg::sie_cfg_t cfg_in,
   input wire logic channel_a_input_in,
   input wire logic channel_b_input_in,
   input wire logic channel_c_input_in,
   input wire logic channel_d_input_in,
   input wire logic reset_request_in,
   output logic eval_output_out,
   output logic [3:0] mode_select_out,
   output logic error_out,
   output logic [3:0] test_pulse_out
);

   logic [31:0] tick_cnt_reg;
   logic ms_tick;
   logic [7:0] filt_ms;
   logic [4:0] raw;
   logic [4:0] flt;
   logic test_hold;
   logic [7:0] settle_ms_reg;
   logic settled;

   sie_pkg::sie_tp_t tp_state_reg;
   logic [9:0] tp_ms_reg;
   logic [1:0] tp_cap_reg;
   logic tp_fail_reg;
   logic tp_active;
   logic [3:0] test_pulse_reg;

   logic act_a;
   logic act_b;
   logic dual;
   logic cond_raw;
   logic disc;
   logic btn1;
   logic btn2;
   logic [3:0] pos_mask;
   logic [3:0] ms_in;
   logic onehot;
   logic idle_ok;

   logic sim_active;
   logic sim_err;
   logic [9:0] sim_ms_reg;

   sie_pkg::sie_th_t th_state_reg;
   logic [9:0] th_ms_reg;
   logic cond;

   logic err_reg;
   logic err_set;
   logic cond_ok;

   logic rst_prev_reg;
   logic rst_seen_reg;
   logic rst_rise;
   logic rst_fall;

   sie_pkg::sie_state_t state_reg;
   sie_pkg::sie_state_t state_next;

   logic eval_out_reg;
   logic [3:0] mode_out_reg;
   logic err_out_reg;

   // Millisecond time base.
   assign ms_tick = (tick_cnt_reg == CYCLES_PER_MS - 32'h0000_0001);

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tick_cnt_reg <= 32'h0000_0000;
      end else if (clk_en_in) begin
         if (ms_tick) begin
            tick_cnt_reg <= 32'h0000_0000;
         end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
         end
      end
   end

   // Filter time is clamped into its legal range.
   always_comb begin
      if (cfg_in.filter_ms < sie_pkg::FILTER_MIN_MS) begin
         filt_ms = sie_pkg::FILTER_MIN_MS;
      end else if (cfg_in.filter_ms > sie_pkg::FILTER_MAX_MS) begin
         filt_ms = sie_pkg::FILTER_MAX_MS;
      end else begin
         filt_ms = cfg_in.filter_ms;
      end
   end

   // The output state machine waits one millisecond longer than the filter time after reset, as unfiltered lines read as low.
   assign settled = (settle_ms_reg > filt_ms);

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         settle_ms_reg <= 8'h00;
      end else if (clk_en_in && ms_tick && !settled) begin
         settle_ms_reg <= settle_ms_reg + 8'h01;
      end
   end

   // The reset line is the input that follows the evaluator inputs.
   assign raw = {reset_request_in, channel_d_input_in, channel_c_input_in,
                 channel_b_input_in, channel_a_input_in};

   generate
      for (genvar i = 0; i < sie_pkg::NUM_FLT; i++) begin : g_flt
         sie_debounce u_flt (
            .sys_clk_in(sys_clk_in),
            .reset_n_in(reset_n_in),
            .clk_en_in(clk_en_in),
            .ms_tick_in(ms_tick),
            .hold_in(test_hold && (i < sie_pkg::RST_CH)),
            .filter_ms_in(filt_ms),
            .raw_in(raw[i]),
            .clean_out(flt[i])
         );
      end
   endgenerate

   // Test pulse sequencer; the light barrier always needs it.
   assign tp_active = (cfg_in.test_en || (cfg_in.eval_kind == sie_pkg::EV_LIGHT_BARRIER))
                      && (cfg_in.eval_kind != sie_pkg::EV_NETWORK);
   assign test_hold = (tp_state_reg != sie_pkg::TP_IDLE);

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tp_state_reg <= sie_pkg::TP_IDLE;
         tp_ms_reg <= 10'h000;
         tp_cap_reg <= 2'h0;
         tp_fail_reg <= 1'b0;
      end else if (clk_en_in) begin
         tp_fail_reg <= 1'b0;
         if (!tp_active) begin
            tp_state_reg <= sie_pkg::TP_IDLE;
            tp_ms_reg <= 10'h000;
         end else if (ms_tick) begin
            case (tp_state_reg)
               sie_pkg::TP_IDLE: begin
                  if (tp_ms_reg >= sie_pkg::TP_PERIOD_MS - 10'h001) begin
                     tp_state_reg <= sie_pkg::TP_LOW;
                     tp_ms_reg <= 10'h000;
                     tp_cap_reg <= raw[1:0] & {dual, 1'b1};
                  end else begin
                     tp_ms_reg <= tp_ms_reg + 10'h001;
                  end
               end
               sie_pkg::TP_LOW: begin
                  if (tp_ms_reg >= sie_pkg::TP_LOW_MS - 10'h001) begin
                     tp_state_reg <= sie_pkg::TP_RECOVER;
                     tp_ms_reg <= 10'h000;
                     tp_fail_reg <= |(tp_cap_reg & raw[1:0]);
                  end else begin
                     tp_ms_reg <= tp_ms_reg + 10'h001;
                  end
               end
               sie_pkg::TP_RECOVER: begin
                  if (tp_ms_reg >= sie_pkg::TP_RECOVER_MS - 10'h001) begin
                     tp_state_reg <= sie_pkg::TP_IDLE;
                     tp_ms_reg <= 10'h000;
                  end else begin
                     tp_ms_reg <= tp_ms_reg + 10'h001;
                  end
               end
               default: begin
                  tp_state_reg <= sie_pkg::TP_IDLE;
                  tp_ms_reg <= 10'h000;
               end
            endcase
         end
      end
   end

   // Only the selected test output is pulled low during a pulse.
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         test_pulse_reg <= sie_pkg::TEST_IDLE;
      end else if (clk_en_in) begin
         if (tp_state_reg == sie_pkg::TP_LOW) begin
            test_pulse_reg <= ~(4'h1 << cfg_in.test_sel);
         end else begin
            test_pulse_reg <= sie_pkg::TEST_IDLE;
         end
      end
   end

   // Input decoding per evaluator kind.
   always_comb begin
      act_a = 1'b0;
      act_b = 1'b0;
      dual = 1'b0;
      btn1 = 1'b0;
      btn2 = 1'b0;
      disc = 1'b0;
      case (cfg_in.eval_kind)
         sie_pkg::EV_FOOTSWITCH: begin
            if (cfg_in.input_type == sie_pkg::IT_SINGLE_NC) begin
               act_a = ~flt[0];
            end else if (cfg_in.input_type == sie_pkg::IT_SINGLE_NO) begin
               act_a = flt[0];
            end else if (cfg_in.input_type == sie_pkg::IT_DOUBLE_NC) begin
               act_a = ~flt[0];
               act_b = ~flt[1];
               dual = 1'b1;
            end else begin
               act_a = flt[0];
               act_b = ~flt[1];
               dual = 1'b1;
            end
         end
         sie_pkg::EV_LIGHT_BARRIER: begin
            act_a = flt[0];
         end
         sie_pkg::EV_SENSOR: begin
            act_a = flt[0];
         end
         sie_pkg::EV_NETWORK: begin
            act_a = flt[0];
            if (cfg_in.input_type == sie_pkg::IT_NET_DOUBLE) begin
               act_b = flt[1];
               dual = 1'b1;
            end
         end
         sie_pkg::EV_TWO_HAND: begin
            if (cfg_in.input_type == sie_pkg::IT_TH_QUAD) begin
               btn1 = flt[0] & ~flt[1];
               btn2 = flt[2] & ~flt[3];
               disc = (flt[0] == flt[1]) || (flt[2] == flt[3]);
            end else begin
               btn1 = flt[0];
               btn2 = flt[1];
            end
         end
         default: begin
            act_a = 1'b0;
         end
      endcase
      if (cfg_in.eval_kind != sie_pkg::EV_TWO_HAND) begin
         disc = dual & (act_a ^ act_b);
      end
   end

   assign cond_raw = act_a & (~dual | act_b);

   // Mode selector one-hot decode over the configured positions.
   always_comb begin
      if (cfg_in.positions == sie_pkg::POS_TWO) begin
         pos_mask = 4'h3;
      end else if (cfg_in.positions == sie_pkg::POS_THREE) begin
         pos_mask = 4'h7;
      end else begin
         pos_mask = 4'hF;
      end
   end

   assign ms_in = flt[3:0] & pos_mask;
   assign onehot = (ms_in != 4'h0) && ((ms_in & (ms_in - 4'h1)) == 4'h0);

   // Skew timer between channels.
   assign sim_active = (cfg_in.eval_kind == sie_pkg::EV_MODE_SEL) ? !onehot
                       : (cfg_in.simult_en & disc);
   assign sim_err = sim_active && (sim_ms_reg > cfg_in.simult_ms);

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sim_ms_reg <= 10'h000;
      end else if (clk_en_in) begin
         if (!sim_active) begin
            sim_ms_reg <= 10'h000;
         end else if (ms_tick && !sim_err) begin
            sim_ms_reg <= sim_ms_reg + 10'h001;
         end
      end
   end

   // Two-hand window; starts locked so both buttons must be released first.
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         th_state_reg <= sie_pkg::TH_LOCKED;
         th_ms_reg <= 10'h000;
      end else if (clk_en_in) begin
         case (th_state_reg)
            sie_pkg::TH_IDLE: begin
               th_ms_reg <= 10'h000;
               if (btn1 && btn2) begin
                  th_state_reg <= sie_pkg::TH_ON;
               end else if (btn1 || btn2) begin
                  th_state_reg <= sie_pkg::TH_FIRST;
               end
            end
            sie_pkg::TH_FIRST: begin
               if (btn1 && btn2) begin
                  th_state_reg <= sie_pkg::TH_ON;
               end else if (!btn1 && !btn2) begin
                  th_state_reg <= sie_pkg::TH_IDLE;
               end else if (ms_tick) begin
                  if (th_ms_reg >= sie_pkg::TH_WINDOW_MS - 10'h001) begin
                     th_state_reg <= sie_pkg::TH_LOCKED;
                  end else begin
                     th_ms_reg <= th_ms_reg + 10'h001;
                  end
               end
            end
            sie_pkg::TH_ON: begin
               if (!btn1 || !btn2) begin
                  th_state_reg <= sie_pkg::TH_LOCKED;
               end
            end
            default: begin
               if (!btn1 && !btn2) begin
                  th_state_reg <= sie_pkg::TH_IDLE;
               end
            end
         endcase
      end
   end

   assign cond = (cfg_in.eval_kind == sie_pkg::EV_TWO_HAND) ? (th_state_reg == sie_pkg::TH_ON)
                 : cond_raw;

   // Error latch; a new error wins over the clear.
   assign err_set = sim_err | tp_fail_reg;

   always_comb begin
      if (cfg_in.eval_kind == sie_pkg::EV_MODE_SEL) begin
         idle_ok = onehot;
      end else if (cfg_in.eval_kind == sie_pkg::EV_TWO_HAND) begin
         idle_ok = !btn1 && !btn2 && !disc;
      end else begin
         idle_ok = !cond_raw && !disc;
      end
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         err_reg <= sie_pkg::ERR_RST;
      end else if (clk_en_in) begin
         if (err_set) begin
            err_reg <= 1'b1;
         end else if (idle_ok) begin
            err_reg <= 1'b0;
         end
      end
   end

   assign cond_ok = cond && !err_reg && !err_set;

   // Reset request edge tracking.
   assign rst_rise = flt[sie_pkg::RST_CH] && !rst_prev_reg;
   assign rst_fall = !flt[sie_pkg::RST_CH] && rst_prev_reg;

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_prev_reg <= 1'b0;
         rst_seen_reg <= 1'b0;
      end else if (clk_en_in) begin
         rst_prev_reg <= flt[sie_pkg::RST_CH];
         if (state_reg != sie_pkg::ST_ARMED) begin
            rst_seen_reg <= 1'b0;
         end else if (rst_rise) begin
            rst_seen_reg <= 1'b1;
         end
      end
   end

   // Output state machine.
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         sie_pkg::ST_START: begin
            if (!settled) begin
               state_next = sie_pkg::ST_START;
            end else if (!cfg_in.startup_en) begin
               state_next = sie_pkg::ST_OFF;
            end else if (cond) begin
               state_next = sie_pkg::ST_START_SEEN;
            end
         end
         sie_pkg::ST_START_SEEN: begin
            if (!cond) begin
               state_next = sie_pkg::ST_OFF;
            end
         end
         sie_pkg::ST_OFF: begin
            if (cond_ok) begin
               if (cfg_in.reset_mode == sie_pkg::RM_NONE) begin
                  state_next = sie_pkg::ST_ON;
               end else begin
                  state_next = sie_pkg::ST_ARMED;
               end
            end
         end
         sie_pkg::ST_ARMED: begin
            if (!cond_ok) begin
               state_next = sie_pkg::ST_OFF;
            end else if ((cfg_in.reset_mode == sie_pkg::RM_MANUAL) && rst_rise) begin
               state_next = sie_pkg::ST_ON;
            end else if ((cfg_in.reset_mode == sie_pkg::RM_MONITORED) && rst_seen_reg
                         && rst_fall) begin
               state_next = sie_pkg::ST_ON;
            end else if (cfg_in.reset_mode == sie_pkg::RM_NONE) begin
               state_next = sie_pkg::ST_ON;
            end
         end
         sie_pkg::ST_ON: begin
            if (!cond_ok) begin
               state_next = sie_pkg::ST_OFF;
            end
         end
         default: begin
            state_next = sie_pkg::ST_START;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_reg <= sie_pkg::ST_START;
      end else if (clk_en_in) begin
         state_reg <= state_next;
      end
   end

   // Registered outputs.
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         eval_out_reg <= sie_pkg::OUT_RST;
         mode_out_reg <= sie_pkg::MODE_OUT_RST;
         err_out_reg <= sie_pkg::ERR_RST;
      end else if (clk_en_in) begin
         eval_out_reg <= (state_next == sie_pkg::ST_ON)
                         && (cfg_in.eval_kind != sie_pkg::EV_MODE_SEL);
         if ((cfg_in.eval_kind == sie_pkg::EV_MODE_SEL) && onehot && !err_reg && !err_set) begin
            mode_out_reg <= ms_in;
         end else begin
            mode_out_reg <= sie_pkg::MODE_OUT_RST;
         end
         err_out_reg <= cfg_in.err_out_en && (err_reg || err_set);
      end
   end

   assign eval_output_out = eval_out_reg;
   assign mode_select_out = mode_out_reg;
   assign error_out = err_out_reg;
   assign test_pulse_out = test_pulse_reg;

endmodule : sie_eval

// [dv/sie_eval_assertions.sv]
// Port checks for the safety input evaluator.
`timescale 1ns/1ps
module sie_eval_assertions #(
   parameter int unsigned CYCLES_PER_MS = 10
) (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire sie_pkg::sie_cfg_t cfg_in,
   input wire logic eval_output_out,
   input wire logic [3:0] mode_select_out,
   input wire logic error_out,
   input wire logic [3:0] test_pulse_out
);
   localparam int PULSE_HI = 26 * CYCLES_PER_MS;
   logic tp_low;
   logic is_mode;
   assign tp_low = test_pulse_out != sie_pkg::TEST_IDLE;
   assign is_mode = cfg_in.eval_kind == sie_pkg::EV_MODE_SEL;
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!reset_n_in);
   a_mode_onehot: assert property ($onehot0(mode_select_out))
      else $error("mode outputs not one-hot");
   a_mode_kind: assert property (!is_mode |-> mode_select_out == 4'h0)
      else $error("mode outputs active in another kind");
   a_mode_main: assert property (is_mode |-> !eval_output_out)
      else $error("main output active in mode kind");
   a_mode_pos: assert property (is_mode && cfg_in.positions == sie_pkg::POS_TWO
      |-> mode_select_out[3:2] == 2'h0) else $error("unused mode position driven");
   a_err_gate: assert property (!cfg_in.err_out_en |-> !error_out)
      else $error("error shown while disabled");
   a_err_low: assert property (error_out [*2] |-> !eval_output_out)
      else $error("output high during error");
   a_pulse_sel: assert property (tp_low |-> $onehot(~test_pulse_out)
      && !test_pulse_out[cfg_in.test_sel]) else $error("wrong test output pulsed");
   a_net_quiet: assert property (cfg_in.eval_kind == sie_pkg::EV_NETWORK |-> !tp_low)
      else $error("test pulse in network kind");
   a_pulse_hold: assert property ($rose(tp_low) |-> tp_low [*8])
      else $error("test pulse too short");
   a_pulse_end: assert property ($rose(tp_low) |-> ##[1:PULSE_HI] !tp_low)
      else $error("test pulse too long");
endmodule : sie_eval_assertions
bind sie_eval sie_eval_assertions #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_chk (
   .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .cfg_in(cfg_in),
   .eval_output_out(eval_output_out), .mode_select_out(mode_select_out),
   .error_out(error_out), .test_pulse_out(test_pulse_out));

// [dv/sie_barrier_model.sv]
// Light barrier that follows its test input after a reaction delay unless stuck_in is set.
`timescale 1ns/1ps
module sie_barrier_model #(
   parameter int unsigned REACT_CYC = 50
) (
   input wire logic sys_clk_in,
   input wire logic beam_clear_in,
   input wire logic stuck_in,
   input wire logic test_in,
   output logic barrier_out
);
   logic [63:0] test_reg = '1;
   always @(posedge sys_clk_in) begin
      test_reg <= {test_reg[62:0], test_in};
   end
   // Unless stuck_in is set, the output drops a fixed time after the test input falls.
   assign barrier_out = beam_clear_in && (stuck_in || test_reg[REACT_CYC - 1]);
endmodule : sie_barrier_model

// [dv/sie_eval_test.sv]
// Self-checking bench for the safety input evaluator.
`timescale 1ns/1ps
module sie_eval_test;
   localparam int unsigned CPM = 10;
   logic sys_clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   sie_pkg::sie_cfg_t cfg = '0;
   sie_pkg::sie_cfg_t nc = '0;
   logic [3:0] ch = 4'h0;
   logic rst_req = 1'b0;
   logic stuck = 1'b0;
   logic ce = 1'b1;
   logic lb_out;
   logic eval_o;
   logic [3:0] mode_o;
   logic err_o;
   logic [3:0] tp_o;
   logic [5:0] exp_q[$];
   int n_mismatch = 0;
   int n_compared = 0;
   event look;
   always #10 sys_clk_in = ~sys_clk_in;
   sie_eval #(.CYCLES_PER_MS(CPM)) dut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
      .clk_en_in(ce), .cfg_in(cfg),
      .channel_a_input_in(cfg.eval_kind == sie_pkg::EV_LIGHT_BARRIER ? lb_out : ch[0]),
      .channel_b_input_in(ch[1]), .channel_c_input_in(ch[2]), .channel_d_input_in(ch[3]),
      .reset_request_in(rst_req), .eval_output_out(eval_o), .mode_select_out(mode_o),
      .error_out(err_o), .test_pulse_out(tp_o));
   sie_barrier_model u_lb (.sys_clk_in(sys_clk_in), .beam_clear_in(ch[0]),
      .stuck_in(stuck), .test_in(tp_o[cfg.test_sel]), .barrier_out(lb_out));
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : give_verdict
   task automatic check(input logic [5:0] seen, input logic [5:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch outputs expected %h seen %h", exp, seen);
      end
   endtask : check
   always @(look) begin
      check({eval_o, mode_o, err_o}, exp_q.pop_front());
   end
   task automatic note(input logic [5:0] e);
      exp_q.push_back(e);
      #1;
      -> look;
   endtask : note
   task automatic drive(input logic [3:0] c, input logic r, input int ms);
      @(posedge sys_clk_in);
      ch <= c;
      rst_req <= r;
      repeat (ms * CPM) @(posedge sys_clk_in);
   endtask : drive
   task automatic restart();
      @(posedge sys_clk_in);
      reset_n_in <= 1'b0;
      cfg <= nc;
      ch <= 4'h0;
      rst_req <= 1'b0;
      stuck <= 1'b0;
      repeat (10) @(posedge sys_clk_in);
      reset_n_in <= 1'b1;
   endtask : restart
   initial begin
      repeat (100000) @(posedge sys_clk_in);
      n_mismatch++;
      give_verdict();
   end
   initial begin
      void'($urandom(41));
      nc.filter_ms = 8'h03;
      nc.simult_ms = 10'h014;
      nc.err_out_en = 1'b1;
      nc.eval_kind = sie_pkg::EV_SENSOR;
      restart();
      drive(4'h1, 0, 1); drive(4'h0, 0, 5); note(6'h00);
      drive(4'h1, 0, 5); note(6'h20);
      drive(4'h0, 0, 5); note(6'h00);
      @(posedge sys_clk_in);
      ce <= 1'b0;
      drive(4'h1, 0, 5); note(6'h00);
      @(posedge sys_clk_in);
      ce <= 1'b1;
      drive(4'h1, 0, 5); note(6'h20);
      nc.startup_en = 1'b1;
      restart();
      drive(4'h1, 0, 5); note(6'h00);
      drive(4'h0, 0, 5); drive(4'h1, 0, 5); note(6'h20);
      nc.startup_en = 1'b0;
      nc.eval_kind = sie_pkg::EV_FOOTSWITCH;
      nc.input_type = sie_pkg::IT_SINGLE_NO;
      nc.reset_mode = sie_pkg::RM_MANUAL;
      restart();
      drive(4'h1, 0, 5); note(6'h00);
      drive(4'h1, 1, 5); note(6'h20);
      drive(4'h0, 1, 5); note(6'h00);
      drive(4'h1, 1, 5); note(6'h00);
      drive(4'h1, 0, 5); drive(4'h1, 1, 5); note(6'h20);
      nc.reset_mode = sie_pkg::RM_MONITORED;
      restart();
      drive(4'h1, 0, 5); drive(4'h1, 1, 5); note(6'h00);
      drive(4'h1, 0, 5); note(6'h20);
      nc.reset_mode = sie_pkg::RM_NONE;
      nc.eval_kind = sie_pkg::EV_MODE_SEL;
      nc.positions = sie_pkg::POS_FOUR;
      restart();
      for (int i = 0; i < 4; i++) begin
         drive(4'h1 << i, 0, 5); note({1'b0, 4'h1 << i, 1'b0});
      end
      drive(4'h3, 0, 5); note(6'h00);
      drive(4'h3, 0, 30); note(6'h01);
      drive(4'h1, 0, 5); note(6'h02);
      nc.positions = sie_pkg::POS_TWO;
      nc.err_out_en = 1'b0;
      restart();
      drive(4'h4, 0, 5); note(6'h00);
      drive(4'h4, 0, 30); note(6'h00);
      nc.eval_kind = sie_pkg::EV_TWO_HAND;
      nc.input_type = sie_pkg::IT_TH_DOUBLE_NO;
      restart();
      drive(4'h1, 0, 100); drive(4'h3, 0, 5); note(6'h20);
      drive(4'h0, 0, 5); note(6'h00);
      drive(4'h1, 0, 600); drive(4'h3, 0, 5); note(6'h00);
      nc.input_type = sie_pkg::IT_TH_QUAD;
      restart();
      drive(4'hA, 0, 5); drive(4'h5, 0, 5); note(6'h20);
      nc.eval_kind = sie_pkg::EV_NETWORK;
      nc.input_type = sie_pkg::IT_NET_DOUBLE;
      nc.simult_en = 1'b1;
      nc.simult_ms = 10'h005;
      nc.err_out_en = 1'b1;
      restart();
      drive(4'h3, 0, 5); note(6'h20);
      drive(4'h1, 0, 20); note(6'h01);
      nc.eval_kind = sie_pkg::EV_LIGHT_BARRIER;
      nc.input_type = sie_pkg::IT_SINGLE_NO;
      nc.simult_en = 1'b0;
      nc.test_sel = 2'($urandom_range(3, 0));
      restart();
      drive(4'h1, 0, 1200); note(6'h20);
      drive(4'h0, 0, 5); note(6'h00);
      stuck <= 1'b1;
      drive(4'h1, 0, 1200); note(6'h01);
      give_verdict();
   end
endmodule : sie_eval_test
